// >>> cdcti_top.sv
// Codec transfer counters, timer, loopback mixer and interrupt flag with AXI4-Lite registers.
`timescale 1ns/100ps
module cdcti_top #(
   parameter int TICK_CYCLES = cdcti_pkg::TICK_CYCLES
) (
   // Clock and reset
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // AXI4-Lite write
   input  wire logic [7:0]           s_awaddr,
   input  wire logic                 s_awvalid,
   output wire logic                 s_awready,
   input  wire logic [31:0]          s_wdata,
   input  wire logic [3:0]           s_wstrb,
   input  wire logic                 s_wvalid,
   output wire logic                 s_wready,
   output logic      [1:0]           s_bresp,
   output logic                      s_bvalid,
   input  wire logic                 s_bready,
   // AXI4-Lite read
   input  wire logic [7:0]           s_araddr,
   input  wire logic                 s_arvalid,
   output wire logic                 s_arready,
   output logic      [31:0]          s_rdata,
   output logic      [1:0]           s_rresp,
   output logic                      s_rvalid,
   input  wire logic                 s_rready,
   // DMA units and data events
   input  wire logic                 play_unit,
   input  wire logic                 cap_unit,
   input  wire logic                 play_byte,
   input  wire logic                 cap_byte,
   input  wire logic                 play_underrun,
   input  wire logic                 cap_word_done,
   input  wire logic                 cap_fifo_empty,
   output wire logic                 play_drq,
   output wire logic                 cap_drq,
   // Audio paths
   input  wire cdcti_pkg::cdcti_frame_t adc_frame,
   input  wire cdcti_pkg::cdcti_frame_t dac_frame,
   output cdcti_pkg::cdcti_frame_t   mix_frame,
   output cdcti_pkg::cdcti_adapt_t   enc_state,
   output cdcti_pkg::cdcti_adapt_t   dec_state,
   input  wire cdcti_pkg::cdcti_adapt_t enc_next,
   input  wire cdcti_pkg::cdcti_adapt_t dec_next,
   output logic                      enc_frozen,
   output logic                      dec_frozen,
   // Interrupt
   output wire logic                 irq
);
   initial begin
      if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) $error("TICK_CYCLES out of range");
   end

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic [31:0] ctrl;
   logic [15:0] play_base, cap_base, timer_base;
   logic [15:0] play_cnt, cap_cnt, timer_cnt;
   logic [15:0] tick_cnt;
   logic [2:0]  flags;
   logic        shared_int;
   logic [1:0]  byte_idx;
   logic [15:0] lb_ctrl;
   logic        aw_held, w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic        prev_play_run, prev_cap_run, prev_timer_run;

   wire wr_fire   = aw_held & w_held & ~s_bvalid;
   wire rd_fire   = s_arvalid & ~s_rvalid;
   assign s_awready = ~aw_held & ~s_bvalid;
   assign s_wready  = ~w_held & ~s_bvalid;
   assign s_arready = ~s_rvalid;

   wire wr_ctrl   = wr_fire && aw_addr == cdcti_pkg::REG_CTRL;
   wire wr_status = wr_fire && aw_addr == cdcti_pkg::REG_STATUS;
   wire wr_flags  = wr_fire && aw_addr == cdcti_pkg::REG_FLAGS;
   wire wr_pbase  = wr_fire && aw_addr == cdcti_pkg::REG_PLAY_BASE;
   wire wr_cbase  = wr_fire && aw_addr == cdcti_pkg::REG_CAP_BASE;
   wire wr_timer  = wr_fire && aw_addr == cdcti_pkg::REG_TIMER;
   wire wr_lb     = wr_fire && aw_addr == cdcti_pkg::REG_LOOPBACK;
   wire wr_known  = wr_ctrl | wr_status | wr_flags | wr_pbase | wr_cbase | wr_timer | wr_lb;

   wire play_run  = ctrl[cdcti_pkg::CTRL_PLAY_RUN];
   wire cap_run   = ctrl[cdcti_pkg::CTRL_CAP_RUN];
   wire play_pio  = ctrl[cdcti_pkg::CTRL_PLAY_PIO];
   wire cap_pio   = ctrl[cdcti_pkg::CTRL_CAP_PIO];
   wire adpcm     = ctrl[cdcti_pkg::CTRL_ADPCM];
   wire mode1     = ctrl[cdcti_pkg::CTRL_MODE_LSB +: 2] == 2'd1;
   wire cap_hold  = ctrl[cdcti_pkg::CTRL_CAP_HOLD];
   wire timer_run = ctrl[cdcti_pkg::CTRL_TIMER_RUN];

   // Mode window guards the PIO select bits.
   wire [31:0] ctrl_keep = 32'h0000_000c;
   wire [31:0] ctrl_mask = ctrl[cdcti_pkg::CTRL_MODE_WIN] ? 32'hffff_ffff : ~ctrl_keep;
   wire [31:0] next_ctrl = (w_data & ctrl_mask) | (ctrl & ~ctrl_mask);

   // ---------------------------------------------------------------
   // Counters
   // ---------------------------------------------------------------
   wire play_dma  = play_run & ~play_pio;
   wire cap_dma   = cap_run & ~cap_pio & ~mode1;
   wire m1_cap    = mode1 & cap_run & ~cap_pio & cap_unit;
   wire play_step = (play_dma & play_unit) | m1_cap;
   wire cap_step  = cap_dma & cap_unit;
   wire play_roll = play_step && play_cnt == 16'h0000;
   wire cap_roll  = cap_step && cap_cnt == 16'h0000;
   wire tick      = timer_run && tick_cnt == 16'(TICK_CYCLES - 1);
   wire timer_roll = tick && timer_cnt == 16'h0000;
   wire [2:0] roll = {timer_roll, cap_roll, play_roll};
   wire [2:0] flag_clr = wr_flags ? ~w_data[2:0] : 3'b000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         play_cnt <= cdcti_pkg::BASE_RESET;
         cap_cnt  <= cdcti_pkg::BASE_RESET;
      end else begin
         if (wr_pbase && s_wstrb[1]) begin
            play_cnt <= w_data[15:0];
         end else if (play_step) begin
            play_cnt <= play_roll ? play_base : play_cnt - 16'h0001;
         end
         if (wr_cbase && s_wstrb[1]) begin
            cap_cnt <= w_data[15:0];
         end else if (cap_step) begin
            cap_cnt <= cap_roll ? cap_base : cap_cnt - 16'h0001;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt       <= 16'h0000;
         timer_cnt      <= cdcti_pkg::BASE_RESET;
         prev_timer_run <= 1'b0;
      end else begin
         prev_timer_run <= timer_run;
         if (!timer_run || tick) begin
            tick_cnt <= 16'h0000;
         end else begin
            tick_cnt <= tick_cnt + 16'h0001;
         end
         if (timer_run && !prev_timer_run) begin
            timer_cnt <= timer_base;
         end else if (tick) begin
            timer_cnt <= timer_roll ? timer_base : timer_cnt - 16'h0001;
         end
      end
   end

   // ---------------------------------------------------------------
   // Flags and interrupt
   // ---------------------------------------------------------------
   wire [2:0] next_flags = wr_status ? roll : ((flags & ~flag_clr) | roll);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags      <= 3'b000;
         shared_int <= 1'b0;
      end else begin
         flags      <= next_flags;
         shared_int <= |next_flags;
      end
   end
   assign irq = shared_int & ctrl[cdcti_pkg::CTRL_UNMASK];

   // ---------------------------------------------------------------
   // ADPCM control
   // ---------------------------------------------------------------
   logic cap_frozen_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_play_run <= 1'b0;
         prev_cap_run  <= 1'b0;
         enc_state     <= '0;
         dec_state     <= '0;
         cap_frozen_q  <= 1'b0;
         dec_frozen    <= 1'b0;
         byte_idx      <= 2'd0;
      end else begin
         prev_play_run <= play_run;
         prev_cap_run  <= cap_run;
         if (!cap_run) begin
            enc_state    <= '0;
            cap_frozen_q <= 1'b0;
         end else begin
            if (cap_hold && cap_word_done) begin
               cap_frozen_q <= 1'b1;
            end else if (!cap_hold) begin
               cap_frozen_q <= 1'b0;
            end
            if (!cap_frozen_q) begin
               enc_state <= enc_next;
            end
         end
         if (play_byte) begin
            dec_frozen <= 1'b0;
         end else if (adpcm && play_underrun) begin
            dec_frozen <= 1'b1;
         end
         if (!play_run || (play_run && !prev_play_run)) begin
            dec_state <= '0;
         end else if (ctrl[cdcti_pkg::CTRL_ACC_CLEAR]) begin
            dec_state.acc <= 16'h0000;
         end else if (!dec_frozen) begin
            dec_state <= dec_next;
         end
         if (adpcm && (play_byte || cap_byte)) begin
            byte_idx <= byte_idx + 2'd1;
         end
      end
   end
   assign enc_frozen = cap_frozen_q;
   // Requests continue across the four bytes; capture stops once held and drained.
   assign play_drq = play_dma;
   assign cap_drq  = (cap_dma | (mode1 & cap_run & ~cap_pio))
                     & ~(cap_frozen_q & cap_fifo_empty);
   wire [7:0] fifo_size = 8'(cdcti_pkg::FIFO_BYTES);
   wire [7:0] fifo_samples = adpcm ? (ctrl[cdcti_pkg::CTRL_CAP_MONO] ? 8'd128 : fifo_size)
                                   : 8'd0;

   // ---------------------------------------------------------------
   // Loopback mixer
   // ---------------------------------------------------------------
   wire lb_on    = lb_ctrl[cdcti_pkg::LB_ON];
   wire [5:0] att_l = lb_ctrl[cdcti_pkg::LB_LEFT_LSB +: cdcti_pkg::ATTEN_W];
   wire [5:0] att_r = lb_ctrl[cdcti_pkg::LB_SPLIT] ?
                      lb_ctrl[cdcti_pkg::LB_RIGHT_LSB +: cdcti_pkg::ATTEN_W] : att_l;
   wire signed [15:0] src_r = ctrl[cdcti_pkg::CTRL_CAP_MONO] ? adc_frame.left
                                                            : adc_frame.right;
   wire signed [15:0] lb_l = lb_on ? (adc_frame.left >>> att_l[3:0]) : 16'sd0;
   wire signed [15:0] lb_r = lb_on ? (src_r >>> att_r[3:0]) : 16'sd0;
   wire signed [16:0] sum_l = 17'(dac_frame.left) + 17'(lb_l);
   wire signed [16:0] sum_r = 17'(dac_frame.right) + 17'(lb_r);

   function automatic logic [15:0] sat(input logic signed [16:0] v);
      if (v[16] != v[15]) begin
         sat = v[16] ? 16'h8000 : 16'h7fff;
      end else begin
         sat = v[15:0];
      end
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mix_frame <= '0;
      end else begin
         mix_frame.left  <= sat(sum_l);
         mix_frame.right <= sat(sum_r);
      end
   end

   // ---------------------------------------------------------------
   // Bus slave
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held    <= 1'b0;
         w_held     <= 1'b0;
         aw_addr    <= 8'h00;
         w_data     <= 32'h0000_0000;
         s_bvalid   <= 1'b0;
         s_bresp    <= cdcti_pkg::RESP_OKAY;
         ctrl       <= cdcti_pkg::CTRL_RESET;
         play_base  <= cdcti_pkg::BASE_RESET;
         cap_base   <= cdcti_pkg::BASE_RESET;
         timer_base <= cdcti_pkg::BASE_RESET;
         lb_ctrl    <= 16'h0000;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_held <= 1'b1;
            aw_addr <= {s_awaddr[7:2], 2'b00};
         end
         if (s_wvalid && s_wready) begin
            w_held <= 1'b1;
            w_data <= s_wdata;
         end
         if (wr_fire) begin
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp  <= wr_known ? cdcti_pkg::RESP_OKAY : cdcti_pkg::RESP_SLVERR;
         end else if (s_bready) begin
            s_bvalid <= 1'b0;
         end
         if (wr_ctrl) ctrl <= next_ctrl;
         if (wr_pbase) play_base <= w_data[15:0];
         if (wr_cbase) cap_base <= w_data[15:0];
         if (wr_timer) timer_base <= w_data[15:0];
         if (wr_lb) lb_ctrl <= w_data[15:0];
      end
   end

   wire [31:0] rd_mux =
      s_araddr[7:2] == cdcti_pkg::REG_CTRL[7:2]      ? ctrl :
      s_araddr[7:2] == cdcti_pkg::REG_STATUS[7:2]    ? {8'h00, fifo_samples, 11'h000,
                                                        byte_idx, play_drq, cap_drq,
                                                        shared_int} :
      s_araddr[7:2] == cdcti_pkg::REG_FLAGS[7:2]     ? {29'h0, flags} :
      s_araddr[7:2] == cdcti_pkg::REG_PLAY_BASE[7:2] ? {16'h0, play_base} :
      s_araddr[7:2] == cdcti_pkg::REG_CAP_BASE[7:2]  ? {16'h0, cap_base} :
      s_araddr[7:2] == cdcti_pkg::REG_TIMER[7:2]     ? {timer_cnt, timer_base} :
      s_araddr[7:2] == cdcti_pkg::REG_LOOPBACK[7:2]  ? {16'h0, lb_ctrl} :
      s_araddr[7:2] == cdcti_pkg::REG_COUNTS[7:2]    ? {cap_cnt, play_cnt} : 32'h0;
   wire rd_known = s_araddr[7:5] == 3'b000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_rvalid <= 1'b0;
         s_rdata  <= 32'h0000_0000;
         s_rresp  <= cdcti_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         s_rvalid <= 1'b1;
         s_rdata  <= rd_mux;
         s_rresp  <= rd_known ? cdcti_pkg::RESP_OKAY : cdcti_pkg::RESP_SLVERR;
      end else if (s_rready) begin
         s_rvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_play_reload: assert property (@(posedge aclk) disable iff (!aresetn)
      (play_roll && !wr_pbase) |=> play_cnt == $past(play_base))
      else $error("playback counter did not reload");
   a_play_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
      play_roll |=> flags[0] && shared_int)
      else $error("playback flag not set on rollunder");
   a_status_clears: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_status && roll == 3'b000) |=> !shared_int)
      else $error("status write did not clear interrupt");
   a_irq_masked: assert property (@(posedge aclk) disable iff (!aresetn)
      !ctrl[cdcti_pkg::CTRL_UNMASK] |-> !irq)
      else $error("irq not held low while masked");
   a_enc_cleared: assert property (@(posedge aclk) disable iff (!aresetn)
      (!cap_run && !$past(cap_run)) |-> enc_state == '0)
      else $error("encoder state not cleared");
   a_upper_load: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_pbase && s_wstrb[1]) |=> play_cnt == $past(w_data[15:0]))
      else $error("upper base write did not load counter");
   a_dma_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      (play_pio && !mode1) |-> !play_step)
      else $error("dma counting in pio mode");
   a_timer_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      timer_roll |=> flags[2] ##0 timer_cnt == $past(timer_base))
      else $error("timer flag or reload wrong");
   a_sat_high: assert property (@(posedge aclk) disable iff (!aresetn)
      (!sum_l[16] && sum_l[15]) |=> mix_frame.left == 16'h7fff)
      else $error("mixer left did not saturate");
   a_cap_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
      (cap_run && cap_frozen_q && $past(cap_frozen_q) && $past(cap_run)) |-> $stable(enc_state))
      else $error("encoder adapted while frozen");
   a_dec_cleared: assert property (@(posedge aclk) disable iff (!aresetn)
      !play_run |=> dec_state == '0)
      else $error("decoder state not cleared");
   a_dec_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
      (play_run && prev_play_run && !ctrl[cdcti_pkg::CTRL_ACC_CLEAR] && dec_frozen)
      |=> $stable(dec_state))
      else $error("decoder adapted while frozen");
   a_byte_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
      (adpcm && (play_byte || cap_byte)) |=> byte_idx == $past(byte_idx) + 2'd1)
      else $error("byte index did not advance");
   a_timer_load: assert property (@(posedge aclk) disable iff (!aresetn)
      (timer_run && !prev_timer_run) |=> timer_cnt == $past(timer_base))
      else $error("timer did not load on enable");
   a_irq_follow: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl[cdcti_pkg::CTRL_UNMASK] |-> irq == shared_int)
      else $error("irq does not follow shared flag");
endmodule // cdcti_top

// >>> cdcti_pkg.sv
// Package holding constants and types of the codec count, timer and interrupt block.
package cdcti_pkg;
   // ---------------------------------------------------------------
   // Notes on behaviour
   // ---------------------------------------------------------------
   // Notes on behaviour
   // - ADPCM packs FIFO fully: 64 bytes, 64 stereo or 128 mono samples.
   // - ADPCM DMA request held over four bytes; PIO status shows byte index.
   // - Capture off holds encoder accumulator and step at zero; on starts encoding.
   // - Capture hold finishes a 4-byte word, freezes, drains, resumes when cleared.
   // - Playback off clears decoder accumulator and step; on starts decoding.
   // - ADPCM playback underrun freezes adaptation until new data arrives.
   // - Accumulator clear bit clears accumulator only; playback toggle clears both.
   // - Upper base write loads concatenated base into current counter.
   // - DMA runs only when enabled and PIO clear; select changes under mode window.
   // - Each DMA unit decrements to zero; next unit interrupts and reloads.
   // - Mode 1 uses playback counter for both directions; modes 0, 2, 3 add capture.
   // - Counter rollunder sets direction flag and shared flag; cleared by writes.
   // - Loopback routes capture data to DAC mix; one attenuation by default.
   // - Split gain: primary field left, second field right; enable gates both.
   // - Mono capture with stereo playback mixes loopback into both channels.
   // - Mixer sum beyond full scale saturates to full-scale code.
   // - Timer loads 16-bit value, ticks about 10 us, flags at zero, reloads.
   // - Any rollover sets shared flag until status write or flags cleared.
   // - Mask low holds IRQ low while shared flag still updates.

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_STATUS    = 8'h04;
   localparam logic [7:0] REG_FLAGS     = 8'h08;
   localparam logic [7:0] REG_PLAY_BASE = 8'h0c;
   localparam logic [7:0] REG_CAP_BASE  = 8'h10;
   localparam logic [7:0] REG_TIMER     = 8'h14;
   localparam logic [7:0] REG_LOOPBACK  = 8'h18;
   localparam logic [7:0] REG_COUNTS    = 8'h1c;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CTRL_PLAY_RUN   = 0;
   localparam int CTRL_CAP_RUN    = 1;
   localparam int CTRL_PLAY_PIO   = 2;
   localparam int CTRL_CAP_PIO    = 3;
   localparam int CTRL_MODE_WIN   = 4;
   localparam int CTRL_TIMER_RUN  = 5;
   localparam int CTRL_UNMASK     = 6;
   localparam int CTRL_CAP_HOLD   = 7;
   localparam int CTRL_ACC_CLEAR  = 8;
   localparam int CTRL_ADPCM      = 9;
   localparam int CTRL_MODE_LSB   = 10;
   localparam int CTRL_CAP_MONO   = 12;
   localparam int FLAG_PLAY       = 0;
   localparam int FLAG_CAP        = 1;
   localparam int FLAG_TIMER      = 2;
   localparam int LB_ON           = 0;
   localparam int LB_SPLIT        = 1;
   localparam int LB_LEFT_LSB     = 2;
   localparam int LB_RIGHT_LSB    = 8;
   localparam int ATTEN_W         = 6;

   // ---------------------------------------------------------------
   // Reset values and timing
   // ---------------------------------------------------------------
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0400;
   localparam logic [15:0] BASE_RESET    = 16'h0000;
   localparam int          FIFO_BYTES    = 64;
   localparam int          WORD_BYTES    = 4;
   localparam int          TICK_NS       = 10000;
   localparam int          CLK_NS        = 20;
   localparam int          TICK_CYCLES   = TICK_NS / CLK_NS;
   localparam logic [1:0]  RESP_OKAY     = 2'b00;
   localparam logic [1:0]  RESP_SLVERR   = 2'b10;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic signed [15:0] left;
      logic signed [15:0] right;
   } cdcti_frame_t;

   typedef struct packed {
      logic [15:0] acc;
      logic [6:0]  step;
   } cdcti_adapt_t;
endpackage

// >>> cdcti_host_model.sv
// Host DMA model that moves one playback unit each time the bench asks for it.
`timescale 1ns/100ps
module cdcti_host_model (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Bench control
   input  wire logic start,
   input  wire logic slow,
   // Device side
   input  wire logic drq,
   output logic      unit,
   output logic      byte_pulse
);
   logic       busy;
   logic [1:0] gap;
   wire logic  fire = busy && gap == 2'h0 && drq;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy <= 1'b0;
         gap  <= 2'h0;
      end else if (start) begin
         busy <= 1'b1;
         gap  <= slow ? 2'h3 : 2'h0;
      end else if (busy && gap != 2'h0) begin
         gap <= gap - 2'h1;
      end else if (fire) begin
         busy <= 1'b0;
      end
   end
   assign unit       = fire;
   assign byte_pulse = fire;
endmodule // cdcti_host_model

// >>> cdcti_top_tb.sv
// Self-checking bench for the codec count, timer and interrupt block.
`timescale 1ns/100ps
module cdcti_top_tb;
   localparam int B = 3;
   logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, go, slow, und;
   logic [7:0] s_awaddr, s_araddr;
   logic [31:0] s_wdata, rd;
   logic [1:0] rr;
   logic [15:0] r = 16'h0032;
   cdcti_pkg::cdcti_frame_t adc, dac;
   cdcti_pkg::cdcti_adapt_t encn, decn, dold;
   wire logic s_awready, s_wready, s_arready, s_bvalid, s_rvalid, pu, pb, pdrq, irq, dfz;
   wire logic [1:0] s_bresp, s_rresp;
   wire logic [31:0] s_rdata;
   wire cdcti_pkg::cdcti_frame_t mix;
   wire cdcti_pkg::cdcti_adapt_t encs, decs;
   int err_count = 0, samples_checked = 0, cnt, flg, n, k, rep;
   cdcti_top #(.TICK_CYCLES(4)) u_dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hf),
      .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
      .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
      .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
      .play_unit(pu), .cap_unit(1'b0), .play_byte(pb), .cap_byte(1'b0), .play_underrun(und),
      .cap_word_done(1'b0), .cap_fifo_empty(slow), .play_drq(pdrq), .cap_drq(),
      .adc_frame(adc), .dac_frame(dac), .mix_frame(mix), .enc_state(encs), .dec_state(decs),
      .enc_next(encn), .dec_next(decn), .enc_frozen(), .dec_frozen(dfz), .irq(irq));
   cdcti_host_model u_host (.aclk(aclk), .aresetn(aresetn), .start(go), .slow(slow),
      .drq(pdrq), .unit(pu), .byte_pulse(pb));
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   function automatic logic [15:0] sat(input int s);
      return s > 32767 ? 16'h7fff : (s < -32768 ? 16'h8000 : 16'(s));
   endfunction
   task automatic finish_test;
      $display("errors %0d checks %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, b;
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(negedge aclk);
         aw = s_awready;
         w = s_wready;
         b = s_bvalid;
         @(posedge aclk);
         if (aw) s_awvalid <= 1'b0;
         if (w) s_wvalid <= 1'b0;
         if (b) begin
            s_bready <= 1'b0;
            @(posedge aclk);
            break;
         end
      end
      if (n == 40) begin
         err_count++;
         finish_test();
      end
   endtask
   task automatic axr(input logic [7:0] a);
      logic ar, v;
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(negedge aclk);
         ar = s_arready;
         v = s_rvalid;
         rd = s_rdata;
         rr = s_rresp;
         @(posedge aclk);
         if (ar) s_arvalid <= 1'b0;
         if (v) begin
            s_rready <= 1'b0;
            @(posedge aclk);
            break;
         end
      end
      if (n == 40) begin
         err_count++;
         finish_test();
      end
   endtask
   task automatic unit;
      go <= 1'b1;
      slow <= r[1];
      r = lfsr(r);
      @(posedge aclk);
      go <= 1'b0;
      for (n = 0; n < 20; n++) begin
         @(negedge aclk);
         if (pu) break;
      end
      @(posedge aclk);
      if (n == 20) begin
         err_count++;
         finish_test();
      end
      if (cnt == 0) begin
         flg = 1;
         cnt = B;
      end else cnt--;
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, go, slow, und} = '0;
      {s_awaddr, s_araddr, s_wdata, adc, dac, encn, decn} = '0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axr(cdcti_pkg::REG_CTRL);
      chk("ctrl reset", cdcti_pkg::CTRL_RESET, rd);
      encn <= {r, r[6:0]};
      decn <= {~r, r[6:0]};
      repeat (3) @(posedge aclk);
      chk("enc idle", 32'h0, 32'(encs));
      chk("dec idle", 32'h0, 32'(decs));
      axw(cdcti_pkg::REG_PLAY_BASE, 32'(B));
      cnt = B;
      flg = 0;
      for (rep = 0; rep < 2; rep++) begin
         axw(cdcti_pkg::REG_CTRL, rep ? 32'h0000_0a01 : 32'h0000_0841);
         for (k = 0; k <= B; k++) begin
            unit();
            axr(cdcti_pkg::REG_FLAGS);
            chk("play flag", 32'(flg), rd & 32'h1);
            axr(cdcti_pkg::REG_STATUS);
            chk("shared flag", 32'(flg), rd & 32'h1);
            chk("irq", 32'(flg & (rep == 0)), {31'h0, irq});
            chk("byte index", rep ? 32'((k + 1) % 4) : 32'h0, (rd >> 3) & 32'h3);
         end
         axw(rep ? cdcti_pkg::REG_FLAGS : cdcti_pkg::REG_STATUS, 32'h0);
         flg = 0;
         axr(cdcti_pkg::REG_FLAGS);
         chk("flag clear", 32'h0, rd & 32'h1);
      end
      dold = decn;
      und <= 1'b1;
      @(posedge aclk);
      und <= 1'b0;
      decn <= ~dold;
      repeat (2) @(posedge aclk);
      chk("dec frozen", 32'h1, 32'(dfz));
      chk("dec held", 32'(dold), 32'(decs));
      unit();
      @(posedge aclk);
      chk("dec resumed", 32'h0, 32'(dfz));
      axw(cdcti_pkg::REG_TIMER, 32'h2);
      axw(cdcti_pkg::REG_CTRL, 32'h0000_0821);
      for (k = 0; k < 100; k++) begin
         axr(cdcti_pkg::REG_FLAGS);
         if (rd[2] === 1'b1) break;
      end
      chk("timer flag", 32'h4, rd & 32'h4);
      axw(cdcti_pkg::REG_CTRL, 32'h0000_0825);
      axr(cdcti_pkg::REG_CTRL);
      chk("pio refused", 32'h0000_0821, rd);
      axw(cdcti_pkg::REG_CTRL, 32'h0000_0831);
      axw(cdcti_pkg::REG_CTRL, 32'h0000_0835);
      axr(cdcti_pkg::REG_CTRL);
      chk("pio taken", 32'h0000_0835, rd);
      chk("no dma in pio", 32'h0, {31'h0, pdrq});
      axr(8'h40);
      chk("unmapped resp", 32'(cdcti_pkg::RESP_SLVERR), 32'(rr));
      for (rep = 0; rep < 2; rep++) begin
         axw(cdcti_pkg::REG_LOOPBACK, rep ? 32'h0000_0207 : 32'h0000_0001);
         for (k = 0; k < 6; k++) begin
            r = lfsr(r);
            adc <= k == 0 ? 32'h7000_9000 : {r, ~r};
            r = lfsr(r);
            dac <= k == 0 ? 32'h7000_9000 : {r, r ^ 16'h5a5a};
            repeat (4) @(posedge aclk);
            chk("mix", {sat((int'(adc.left) >>> rep) + int'(dac.left)),
               sat((int'(adc.right) >>> (2 * rep)) + int'(dac.right))}, mix);
         end
      end
      finish_test();
   end
endmodule // cdcti_top_tb
